// *** rtl/ulf_core.sv ***
// UART interrupt priority encoder and line format control
// Operation
// R1 - Source register read returns code of highest pending interrupt.
// R2 - Lower levels hidden until higher serviced; host must re-read.
// R3 - Line status is level 1, code 0110.
// R4 - Received data available is level 2, code 0100.
// R5 - Receive time-out is level 2, code 1100.
// R6 - Transmit holding empty is level 3, code 0010.
// R7 - Modem status change is level 4, code 0000.
// R8 - Bit 0 low when pending, high when none; resets high.
// R9 - Bits 3 to 1 carry priority code, reset zero.
// R10 - Bits 7:6 read 11 with queues enabled, 00 otherwise.
// R11 - Format bit 7 selects divisor latch access, resets 0.
// R12 - Format bit 6 holds serial output low for break.
// R13 - Parity none, odd or even from format bits 5:3.
// R14 - Forced one and forced zero parity codes also provided.
// R15 - Bit 2 gives one, one and half, or two stop bits.
// R16 - Bits 1:0 select five to eight bit characters.
// R17 - Queue control bit 0 enables both queues, resets off.
// R18 - Source bits 5:4 read zero; writes there are ignored.
// R19 - Code follows live sources; next level shows on next read.
module ulf_core #(
  parameter int ADDR_WIDTH = ulf_pkg::ADDR_W
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic RD_WR,
  input wire logic [ADDR_WIDTH-1:0] ADDR,
  input wire logic [7:0] D_IN,
  output logic [7:0] D_OUT,
  output logic D_OE,
  input wire ulf_pkg::ulf_sources_t SOURCES,
  input wire logic TX_SERIAL_IN,
  output logic TX_OUT,
  output ulf_pkg::ulf_format_t FORMAT,
  output logic FIFO_ENABLE
);
  import ulf_pkg::*;

  if (ADDR_WIDTH != ADDR_W) begin : g_bad_width
    $error("ADDR_WIDTH must match the register map");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] lcr_ff;
  logic fifo_en_ff;
  logic [7:0] dout_ff;
  logic doe_ff;
  logic tx_ff;
  ulf_format_t fmt_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire access = !CS_N;
  wire rd_isr = access && RD_WR && (ADDR == ISR_OFFSET);
  wire rd_lcr = access && RD_WR && (ADDR == LCR_OFFSET);
  // R18 isr not writable
  wire wr_fcr = access && !RD_WR && (ADDR == FCR_OFFSET);
  wire wr_lcr = access && !RD_WR && (ADDR == LCR_OFFSET);

  // ----------------------------------------------------------------
  // Priority encoder
  // ----------------------------------------------------------------
  // R1 highest wins
  // R2 lower masked, R19 live sources
  // Time-out outranks plain data within level 2: it carries more news
  logic [3:0] code;
  always_comb begin
    if (SOURCES.line_status) begin
      // R3 line status
      code = CODE_LINE;
    end else if (SOURCES.rx_timeout) begin
      // R5 time-out code
      code = CODE_TIMEOUT;
    end else if (SOURCES.rx_data) begin
      // R4 data available
      code = CODE_RXDATA;
    end else if (SOURCES.tx_empty) begin
      // R6 holding empty
      code = CODE_TXEMPTY;
    end else if (SOURCES.modem) begin
      // R7 modem change
      code = CODE_MODEM;
    end else begin
      // R8 none pending
      code = CODE_NONE;
    end
  end

  // R10 queue indication
  wire [1:0] fifo_bits = fifo_en_ff ? FIFO_ON_BITS : 2'h0;
  // R9 code bits, R18 zero bits
  wire [7:0] isr_val = {fifo_bits, 2'h0, code};
  wire [7:0] rd_data = rd_isr ? isr_val :
                       rd_lcr ? lcr_ff : UNMAPPED_READ;

  // ----------------------------------------------------------------
  // Format decode
  // ----------------------------------------------------------------
  // R13 parity, R14 forced codes
  // Printed forced-one code clashes with odd; 101 taken as forced one
  logic [2:0] par_sel;
  ulf_parity_t par;
  assign par_sel = lcr_ff[5:3];
  always_comb begin
    unique casez (par_sel)
      3'b??0: par = ULF_PAR_NONE;
      3'b001: par = ULF_PAR_ODD;
      3'b011: par = ULF_PAR_EVEN;
      3'b101: par = ULF_PAR_ONE;
      3'b111: par = ULF_PAR_ZERO;
    endcase
  end

  ulf_format_t nxt_fmt;
  always_comb begin
    // R16 word length
    nxt_fmt.word_bits = 4'h5 + {2'h0, lcr_ff[1:0]};
    // R15 stop bits
    nxt_fmt.half_stop = lcr_ff[LCR_STOP_BIT] && (lcr_ff[1:0] == 2'h0);
    nxt_fmt.two_stop = lcr_ff[LCR_STOP_BIT] && (lcr_ff[1:0] != 2'h0);
    nxt_fmt.parity = par;
    // R11 divisor access
    nxt_fmt.divisor_access = lcr_ff[LCR_DLAB_BIT];
    nxt_fmt.break_on = lcr_ff[LCR_BREAK_BIT];
  end

  // R12 break forces low
  wire nxt_tx = lcr_ff[LCR_BREAK_BIT] ? 1'b0 : TX_SERIAL_IN;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lcr_ff <= LCR_RESET;
    end else if (wr_lcr) begin
      lcr_ff <= D_IN;
    end
  end

  // R17 queue enable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fifo_en_ff <= 1'b0;
    end else if (wr_fcr) begin
      fifo_en_ff <= D_IN[FCR_ENABLE_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
    end else begin
      dout_ff <= rd_data;
      doe_ff <= access && RD_WR;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_ff <= 1'b1;
      fmt_ff <= '0;
    end else begin
      tx_ff <= nxt_tx;
      fmt_ff <= nxt_fmt;
    end
  end

  assign D_OUT = dout_ff;
  assign D_OE = doe_ff;
  assign TX_OUT = tx_ff;
  assign FORMAT = fmt_ff;
  assign FIFO_ENABLE = fifo_en_ff;
endmodule : ulf_core

// *** rtl/ulf_pkg.sv ***
// Package for the UART interrupt priority and line format block
package ulf_pkg;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] ISR_OFFSET = 3'h2;
  localparam logic [2:0] FCR_OFFSET = 3'h2;
  localparam logic [2:0] LCR_OFFSET = 3'h3;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LCR_DLAB_BIT = 7;
  localparam int LCR_BREAK_BIT = 6;
  localparam int LCR_STOP_BIT = 2;
  localparam int FCR_ENABLE_BIT = 0;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] ISR_RESET = 8'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ----------------------------------------------------------------
  // Interrupt codes, bits 3 to 0
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_LINE = 4'h6;
  localparam logic [3:0] CODE_RXDATA = 4'h4;
  localparam logic [3:0] CODE_TIMEOUT = 4'hc;
  localparam logic [3:0] CODE_TXEMPTY = 4'h2;
  localparam logic [3:0] CODE_MODEM = 4'h0;
  localparam logic [3:0] CODE_NONE = 4'h1;
  localparam logic [1:0] FIFO_ON_BITS = 2'h3;

  typedef enum logic [2:0] {
    ULF_PAR_NONE, ULF_PAR_ODD, ULF_PAR_EVEN, ULF_PAR_ONE, ULF_PAR_ZERO
  } ulf_parity_t;

  typedef struct packed {
    logic [3:0] word_bits;
    logic two_stop;
    logic half_stop;
    ulf_parity_t parity;
    logic divisor_access;
    logic break_on;
  } ulf_format_t;

  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic tx_empty;
    logic modem;
  } ulf_sources_t;
endpackage : ulf_pkg

// *** tb/ulf_monitor.sv ***
// Checker for the priority and line format block
module ulf_monitor
  import ulf_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic RD_WR,
  input wire logic [ulf_pkg::ADDR_W-1:0] ADDR,
  input wire logic [7:0] D_OUT,
  input wire ulf_pkg::ulf_sources_t SOURCES,
  input wire logic TX_OUT,
  input wire ulf_pkg::ulf_format_t FORMAT,
  input wire logic FIFO_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire ri = !CS_N && RD_WR && ADDR == ISR_OFFSET;
  property p_brk; FORMAT.break_on |-> !TX_OUT; endproperty
  a_brk: assert property (p_brk) else $error("break");
  property p_lin; ri && SOURCES[4] |=> D_OUT[3:0] == 4'h6; endproperty
  a_lin: assert property (p_lin) else $error("line");
  property p_tmo; ri && SOURCES[4:2] == 3'h1 |=> D_OUT[3:0] == 4'hc;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout");
  property p_rxd; ri && SOURCES[4:2] == 3'h2 |=> D_OUT[3:0] == 4'h4;
  endproperty
  a_rxd: assert property (p_rxd) else $error("rx data");
  property p_non; ri && SOURCES == '0 |=> D_OUT[3:0] == 4'h1; endproperty
  a_non: assert property (p_non) else $error("none");
  property p_fif; ri |=> D_OUT[7:6] == {2{FIFO_ENABLE}}; endproperty
  a_fif: assert property (p_fif) else $error("fifo bits");
  property p_unu; ri |=> D_OUT[5:4] == 2'h0; endproperty
  a_unu: assert property (p_unu) else $error("unused bits");
  property p_wl; $past(RSTN) |-> FORMAT.word_bits inside {[5:8]}; endproperty
  a_wl: assert property (p_wl) else $error("length");
  c_lin: cover property (ri && SOURCES[4]);
  c_brk: cover property (FORMAT.break_on);
  c_fif: cover property (ri && FIFO_ENABLE);
endmodule : ulf_monitor
bind ulf_core ulf_monitor mon (
  .CLK(CLK),
  .RSTN(RSTN),
  .CS_N(CS_N),
  .RD_WR(RD_WR),
  .ADDR(ADDR),
  .D_OUT(D_OUT),
  .SOURCES(SOURCES),
  .TX_OUT(TX_OUT),
  .FORMAT(FORMAT),
  .FIFO_ENABLE(FIFO_ENABLE)
);

// *** tb/ulf_host.sv ***
// Host bus model for the register port
module ulf_host (
  input wire logic CLK,
  output logic CS_N,
  output logic RD_WR,
  output logic [2:0] ADDR,
  output logic [7:0] D_IN,
  input wire logic [7:0] D_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    CS_N = 1'b1;
    RD_WR = 1'b1;
    ADDR = 3'h0;
    D_IN = 8'h00;
  end
  task automatic acc(input logic w, input logic [2:0] a,
    input logic [7:0] v, output logic [7:0] q);
    @(negedge CLK);
    CS_N = 1'b0;
    RD_WR = !w;
    ADDR = a;
    D_IN = v;
    @(negedge CLK);
    q = D_OUT;
    CS_N = 1'b1;
    ADDR = ~a;
    D_IN = ~v;
  endtask : acc
endmodule : ulf_host

// *** tb/test_uart_irq_priority_and_line_format.sv ***
// Self-checking bench for the priority and line format block
module test_uart_irq_priority_and_line_format;
  timeunit 1ns;
  timeprecision 1ps;
  import ulf_pkg::*;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic TX_SERIAL_IN = 1'b1;
  logic CS_N, RD_WR, D_OE, TX_OUT, FIFO_ENABLE;
  logic [2:0] ADDR;
  logic [7:0] D_IN, D_OUT, q;
  ulf_sources_t SOURCES = '0;
  ulf_format_t FORMAT;
  int n_mismatch = 0;
  int tests_run = 0;
  ulf_core DUT (
    .CLK(CLK),
    .RSTN(RSTN),
    .CS_N(CS_N),
    .RD_WR(RD_WR),
    .ADDR(ADDR),
    .D_IN(D_IN),
    .D_OUT(D_OUT),
    .D_OE(D_OE),
    .SOURCES(SOURCES),
    .TX_SERIAL_IN(TX_SERIAL_IN),
    .TX_OUT(TX_OUT),
    .FORMAT(FORMAT),
    .FIFO_ENABLE(FIFO_ENABLE)
  );
  ulf_host h (
    .CLK(CLK),
    .CS_N(CS_N),
    .RD_WR(RD_WR),
    .ADDR(ADDR),
    .D_IN(D_IN),
    .D_OUT(D_OUT)
  );
  always #2 CLK = ~CLK;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic t_prio;
    logic [4:0] s [6] = '{5'h1f, 5'h0f, 5'h0b, 5'h03, 5'h01, 5'h00};
    logic [3:0] c [6] = '{4'h6, 4'hc, 4'h4, 4'h2, 4'h0, 4'h1};
    h.acc(1'b0, 3'h2, 8'h00, q);
    chk({8'h00, q}, 16'h0001);
    chk({15'h0000, D_OE}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      SOURCES = s[i];
      h.acc(1'b0, 3'h2, 8'h00, q);
      chk({8'h00, q}, {12'h000, c[i]});
    end
    h.acc(1'b1, 3'h2, 8'h01, q);
    h.acc(1'b0, 3'h2, 8'h00, q);
    chk({7'h00, FIFO_ENABLE, q}, 16'h01c1);
    h.acc(1'b1, 3'h2, 8'h00, q);
    h.acc(1'b0, 3'h2, 8'h00, q);
    chk({7'h00, FIFO_ENABLE, q}, 16'h0001);
  endtask : t_prio
  task automatic t_fmt;
    logic [19:0] t [10] = '{20'h00501, 20'h04541, 20'h0e789, 20'h1b811,
      20'h2d699, 20'h39621, 20'h30501, 20'h81605, 20'h4a70a, 20'h00501};
    h.acc(1'b0, 3'h3, 8'h00, q);
    chk({8'h00, q}, 16'h0000);
    foreach (t[i]) begin
      h.acc(1'b1, 3'h3, t[i][19:12], q);
      h.acc(1'b0, 3'h3, 8'h00, q);
      chk({8'h00, q}, {8'h00, t[i][19:12]});
      chk({15'h0000, D_OE}, 16'h0001);
      @(negedge CLK);
      chk({4'h0, FORMAT, TX_OUT}, {4'h0, t[i][11:0]});
      chk({15'h0000, D_OE}, 16'h0000);
    end
  endtask : t_fmt
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(negedge CLK);
    RSTN = 1'b1;
    t_prio();
    t_fmt();
    wrap_up();
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule : test_uart_irq_priority_and_line_format
